// ---- hdl/wes_edge_detect.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Pin synchroniser and polarity-selected edge detector.
// ****************************************************************
module wes_edge_detect import wes_pkg::*; (
   // Clock and reset.
   input  wire logic            clk,
   input  wire logic            rst_n,
   // Raw pins and polarity choice.
   input  wire logic [PINS-1:0] pins_in,
   input  wire logic [PINS-1:0] pol,
   // Stable levels and edge hits, both registered.
   output wes_pins_type         det
);

   logic [PINS-1:0] lvl_vec;
   logic [PINS-1:0] hit_vec;

   genvar i;
   generate
      for (i = 0; i < PINS; i = i + 1) begin : g_pin
         logic s1_reg, s2_reg, s3_reg, lvl_reg, hit_reg;
         logic lvl_next, hit_next;

         // A level counts only once the second and third stages agree.
         // synchronise then detect
         always_comb begin
            lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
            hit_next = (lvl_next != lvl_reg) && (lvl_next == pol[i]);
         end

         // The stable level idles high, so no edge is seen at reset release.
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_reg  <= SYNC_RESET;
               s2_reg  <= SYNC_RESET;
               s3_reg  <= SYNC_RESET;
               lvl_reg <= SYNC_RESET;
               hit_reg <= 1'h0;
            end else begin
               s1_reg  <= pins_in[i];
               s2_reg  <= s1_reg;
               s3_reg  <= s2_reg;
               lvl_reg <= lvl_next;
               hit_reg <= hit_next;
            end
         end

         assign lvl_vec[i] = lvl_reg;
         assign hit_vec[i] = hit_reg;
      end
   endgenerate

   // Pack the per-pin results for the register block.
   assign det = '{level: lvl_vec, hit: hit_vec};

endmodule // wes_edge_detect

// ---- hdl/wes_irq_status.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Sticky event status with mask and one level interrupt.
// ****************************************************************
module wes_irq_status import wes_pkg::*; (
   // Clock and reset.
   input  wire logic            clk,
   input  wire logic            rst_n,
   // Events, software clears and mask.
   input  wire logic [PINS-1:0] set,
   input  wire logic [PINS-1:0] clr,
   input  wire logic [PINS-1:0] mask,
   // Status and interrupt, registered.
   output logic      [PINS-1:0] status,
   output logic                 irq
);

   logic [PINS-1:0] status_reg, status_next;
   logic            irq_reg, irq_next;

   // A new event wins over a clear in the same cycle, so none is lost.
   always_comb begin
      status_next = (status_reg & ~clr) | set;
      irq_next    = |(status_next & mask);
   end

   // Status and interrupt registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= STATUS_RESET;
         irq_reg    <= 1'h0;
      end else begin
         status_reg <= status_next;
         irq_reg    <= irq_next;
      end
   end

   assign status = status_reg;
   assign irq    = irq_reg;

endmodule // wes_irq_status

// ---- hdl/wes_pkg.sv ----
// ****************************************************************
// Shared constants and types of the wakeup edge select block.
// ****************************************************************
package wes_pkg;

   // Number of wakeup pins; the top one doubles as converter trigger.
   localparam int          PINS         = 6;
   localparam int          TRIG_PIN     = 5;
   localparam int          ADDR_W       = 8;
   localparam int          DATA_W       = 32;
   localparam int          STRB_W       = 4;
   localparam int          BYTE0        = 0;

   // Byte addresses of the word registers.
   localparam logic [7:0]  OFF_EDGE_POL = 8'h00;
   localparam logic [7:0]  OFF_STATUS   = 8'h04;
   localparam logic [7:0]  OFF_MASK     = 8'h08;
   localparam logic [7:0]  OFF_LEVEL    = 8'h0C;

   // Reset values and fixed fields.
   localparam logic [5:0]  POL_RESET    = 6'h00;
   localparam logic [5:0]  STATUS_RESET = 6'h00;
   localparam logic [5:0]  MASK_RESET   = 6'h00;
   localparam logic [1:0]  POL_RSVD_VAL = 2'h3;
   localparam logic        SYNC_RESET   = 1'h1;
   localparam logic [23:0] PAD_POL      = 24'h00_0000;
   localparam logic [25:0] PAD_SIX      = 26'h000_0000;
   localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;

   // Bus response codes.
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_DECERR  = 2'h3;

   // Read channel states.
   typedef enum logic {
      RD_IDLE,
      RD_RESP
   } wes_rd_state_type;

   // Debounced pin levels and their one-cycle edge hits.
   typedef struct packed {
      logic [PINS-1:0] level;
      logic [PINS-1:0] hit;
   } wes_pins_type;

   // A write held until both address and data have arrived.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [STRB_W-1:0] strb;
   } wes_wcmd_type;

endpackage

// ---- hdl/wes_wakeup_edge_select.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Wakeup edge select: polarity register, edge events, bus slave.
// ****************************************************************

module wes_wakeup_edge_select import wes_pkg::*; (
   // Clock and reset.
   input  wire logic              MCLK,
   input  wire logic              RST_N,
   // Write address channel.
   input  wire logic [ADDR_W-1:0] AWADDR,
   input  wire logic              AWVALID,
   output logic                   AWREADY,
   // Write data channel.
   input  wire logic [DATA_W-1:0] WDATA,
   input  wire logic [STRB_W-1:0] WSTRB,
   input  wire logic              WVALID,
   output logic                   WREADY,
   // Write response channel.
   output logic      [1:0]        BRESP,
   output logic                   BVALID,
   input  wire logic              BREADY,
   // Read address channel.
   input  wire logic [ADDR_W-1:0] ARADDR,
   input  wire logic              ARVALID,
   output logic                   ARREADY,
   // Read data channel.
   output logic      [DATA_W-1:0] RDATA,
   output logic      [1:0]        RRESP,
   output logic                   RVALID,
   input  wire logic              RREADY,
   // Wakeup pins; the top one is also the converter trigger pin.
   input  wire logic [PINS-1:0]   WAKE_IN,
   // Edge requests and interrupt.
   output logic      [PINS-1:0]   WAKE_REQ,
   output logic                   CONV_TRIG,
   output logic                   IRQ
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************

   // Software-visible state.
   logic [PINS-1:0]   pol_reg, pol_next;
   logic [PINS-1:0]   mask_reg, mask_next;
   logic [PINS-1:0]   clr_pulse;
   logic [PINS-1:0]   status;

   // Write channel state.
   logic              awready_reg, awready_next;
   logic              wready_reg, wready_next;
   logic              bvalid_reg, bvalid_next;
   logic [1:0]        bresp_reg, bresp_next;
   wes_wcmd_type      wcmd_reg, wcmd_next;
   logic              commit;

   // Read channel state.
   wes_rd_state_type  rd_state_reg, rd_state_next;
   logic              arready_reg, arready_next;
   logic              rvalid_reg, rvalid_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [1:0]        rresp_reg, rresp_next;
   logic [DATA_W-1:0] rd_word;
   logic [1:0]        rd_resp;

   // Pin results.
   wes_pins_type      det;

   // ****************************************************************
   // Edge detection and event status.
   // ****************************************************************

   // Each pin bit of the polarity register steers its own detector.
   // polarity feeds detectors
   wes_edge_detect u_detect (
      .clk     (MCLK),
      .rst_n   (RST_N),
      .pins_in (WAKE_IN),
      .pol     (pol_reg),
      .det     (det)
   );

   // Edge hits are the events that set sticky status bits.
   wes_irq_status u_irq (
      .clk    (MCLK),
      .rst_n  (RST_N),
      .set    (det.hit),
      .clr    (clr_pulse),
      .mask   (mask_reg),
      .status (status),
      .irq    (IRQ)
   );

   // Requests leave straight from the detector's hit flops.
   assign WAKE_REQ  = det.hit;
   // The shared pin uses the very same bit, so both uses agree on polarity.
   // shared trigger polarity
   assign CONV_TRIG = det.hit[TRIG_PIN];

   // ****************************************************************
   // Write path.
   // ****************************************************************

   // A write is done once both halves are held and no response is pending.
   assign commit = !awready_reg && !wready_reg && !bvalid_reg;

   // Address and data are taken in either order and held until commit.
   always_comb begin
      awready_next = awready_reg;
      wready_next  = wready_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      wcmd_next    = wcmd_reg;
      pol_next     = pol_reg;
      mask_next    = mask_reg;
      clr_pulse    = STATUS_RESET;
      if (AWVALID && awready_reg) begin
         awready_next  = 1'h0;
         wcmd_next.addr = AWADDR;
      end
      if (WVALID && wready_reg) begin
         wready_next    = 1'h0;
         wcmd_next.data = WDATA;
         wcmd_next.strb = WSTRB;
      end
      if (bvalid_reg && BREADY) begin
         bvalid_next = 1'h0;
      end
      if (commit) begin
         awready_next = 1'h1;
         wready_next  = 1'h1;
         bvalid_next  = 1'h1;
         bresp_next   = RESP_OKAY;
         case (wcmd_reg.addr)
            OFF_EDGE_POL: begin
               // Reserved upper bits are dropped; they have no storage.
               // store edge selects
               if (wcmd_reg.strb[BYTE0]) begin
                  pol_next = wcmd_reg.data[PINS-1:0];
               end
            end
            OFF_STATUS: begin
               // Writing a one clears that status bit.
               if (wcmd_reg.strb[BYTE0]) begin
                  clr_pulse = wcmd_reg.data[PINS-1:0];
               end
            end
            OFF_MASK: begin
               if (wcmd_reg.strb[BYTE0]) begin
                  mask_next = wcmd_reg.data[PINS-1:0];
               end
            end
            OFF_LEVEL: begin
               // Pin levels are read only; the write is accepted and ignored.
               bresp_next = RESP_OKAY;
            end
            default: begin
               bresp_next = RESP_DECERR;
            end
         endcase
      end
   end

   // Write path registers; selects reset to falling-edge detection.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         awready_reg <= 1'h1;
         wready_reg  <= 1'h1;
         bvalid_reg  <= 1'h0;
         bresp_reg   <= RESP_OKAY;
         wcmd_reg    <= '0;
         pol_reg     <= POL_RESET;
         mask_reg    <= MASK_RESET;
      end else begin
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         wcmd_reg    <= wcmd_next;
         pol_reg     <= pol_next;
         mask_reg    <= mask_next;
      end
   end

   // ****************************************************************
   // Read path.
   // ****************************************************************

   // Read multiplexer; data above the low byte reads as zero.
   always_comb begin
      rd_word = ZERO_WORD;
      rd_resp = RESP_OKAY;
      case (ARADDR)
         OFF_EDGE_POL: begin
            rd_word = {PAD_POL, POL_RSVD_VAL, pol_reg};
         end
         OFF_STATUS: begin
            rd_word = {PAD_SIX, status};
         end
         OFF_MASK: begin
            rd_word = {PAD_SIX, mask_reg};
         end
         OFF_LEVEL: begin
            rd_word = {PAD_SIX, det.level};
         end
         default: begin
            rd_resp = RESP_DECERR;
         end
      endcase
   end

   // One read at a time; the address is refused while the data waits.
   always_comb begin
      rd_state_next = rd_state_reg;
      arready_next  = arready_reg;
      rvalid_next   = rvalid_reg;
      rdata_next    = rdata_reg;
      rresp_next    = rresp_reg;
      case (rd_state_reg)
         RD_IDLE: begin
            if (ARVALID) begin
               rd_state_next = RD_RESP;
               arready_next  = 1'h0;
               rvalid_next   = 1'h1;
               rdata_next    = rd_word;
               rresp_next    = rd_resp;
            end
         end
         RD_RESP: begin
            if (RREADY) begin
               rd_state_next = RD_IDLE;
               arready_next  = 1'h1;
               rvalid_next   = 1'h0;
            end
         end
         default: begin
            rd_state_next = RD_IDLE;
            arready_next  = 1'h1;
            rvalid_next   = 1'h0;
         end
      endcase
   end

   // Read path registers.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         rd_state_reg <= RD_IDLE;
         arready_reg  <= 1'h1;
         rvalid_reg   <= 1'h0;
         rdata_reg    <= ZERO_WORD;
         rresp_reg    <= RESP_OKAY;
      end else begin
         rd_state_reg <= rd_state_next;
         arready_reg  <= arready_next;
         rvalid_reg   <= rvalid_next;
         rdata_reg    <= rdata_next;
         rresp_reg    <= rresp_next;
      end
   end

   // ****************************************************************
   // Outputs, all straight from flops.
   // ****************************************************************

   assign AWREADY = awready_reg;
   assign WREADY  = wready_reg;
   assign BVALID  = bvalid_reg;
   assign BRESP   = bresp_reg;
   assign ARREADY = arready_reg;
   assign RVALID  = rvalid_reg;
   assign RDATA   = rdata_reg;
   assign RRESP   = rresp_reg;

endmodule // wes_wakeup_edge_select

// ---- sim/wes_pin_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// External wakeup pins, idle high like pulled-up lines.
// ****************************************************************
module wes_pin_model import wes_pkg::*; (
   // Clock.
   input  wire logic            clk,
   // Commanded level and delay in cycles.
   input  wire logic [PINS-1:0] cmd,
   input  wire logic [3:0]      dly,
   // Pins.
   output logic      [PINS-1:0] pins
);
   logic [PINS-1:0] cmd_seen = 6'h3F;
   logic [PINS-1:0] pins_reg = 6'h3F;
   logic [3:0]      wait_cnt = 4'h0;

   // A new command waits its delay, then lands on a rising edge by a
   // non-blocking update, so the synchroniser never races the model.
   always @(posedge clk) begin
      if (cmd !== cmd_seen) begin
         cmd_seen <= cmd;
         wait_cnt <= dly;
      end else if (wait_cnt != 4'h0) begin
         wait_cnt <= wait_cnt - 4'h1;
      end else begin
         pins_reg <= cmd_seen;
      end
   end

   // The pins show the last level that was applied.
   assign pins = pins_reg;
endmodule // wes_pin_model

// ---- sim/wes_props.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Port checker of the wakeup edge select block.
// ****************************************************************
module wes_props import wes_pkg::*; (
   // Clock and reset.
   input wire logic              MCLK,
   input wire logic              RST_N,
   // Write channels.
   input wire logic              AWVALID,
   input wire logic              AWREADY,
   input wire logic              WVALID,
   input wire logic              WREADY,
   input wire logic [1:0]        BRESP,
   input wire logic              BVALID,
   input wire logic              BREADY,
   // Read channels.
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic              ARVALID,
   input wire logic              ARREADY,
   input wire logic [DATA_W-1:0] RDATA,
   input wire logic [1:0]        RRESP,
   input wire logic              RVALID,
   input wire logic              RREADY,
   // Requests.
   input wire logic [PINS-1:0]   WAKE_REQ,
   input wire logic              CONV_TRIG
);
   logic [ADDR_W-1:0] ar_addr_reg;

   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   // The read address is kept so that returned data can be judged.
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) ar_addr_reg <= 8'h00;
      else if (ARVALID && ARREADY) ar_addr_reg <= ARADDR;
   end

   // Handshake steps that start a read and a write.
   sequence ar_take;
      ARVALID && ARREADY;
   endsequence
   sequence w_both;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence

   conv_trig_a: assert property (CONV_TRIG == WAKE_REQ[TRIG_PIN])
      else $error("Trigger request differs from pin five request.");
   req_pulse_a: assert property ((WAKE_REQ != 6'h00) |=>
      ((WAKE_REQ & $past(WAKE_REQ)) == 6'h00))
      else $error("Edge request lasted more than one cycle.");
   read_lat_a: assert property (ar_take |=> RVALID)
      else $error("Read data did not follow the address.");
   arready_low_a: assert property (RVALID |-> !ARREADY)
      else $error("Read address accepted while data pending.");
   rdata_hold_a: assert property (RVALID && !RREADY |=>
      RVALID && $stable(RDATA) && $stable(RRESP))
      else $error("Read data changed before it was taken.");
   bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("Write response changed before it was taken.");
   write_resp_a: assert property (w_both |-> ##[1:3] BVALID)
      else $error("Write response missing.");
   rsvd_ones_a: assert property (RVALID && RRESP == RESP_OKAY &&
      ar_addr_reg == OFF_EDGE_POL |-> RDATA[31:6] == 26'h000_0003)
      else $error("Reserved polarity bits did not read as ones.");
   decerr_zero_a: assert property (RVALID && RRESP == RESP_DECERR |-> RDATA == ZERO_WORD)
      else $error("Refused read returned data.");
endmodule // wes_props

// ---- sim/wes_wakeup_edge_select_tb_top.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Testbench of the wakeup edge select block.
// ****************************************************************
module wes_wakeup_edge_select_tb_top import wes_pkg::*;;
   logic              MCLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic              AWREADY, WREADY, BVALID, ARREADY, RVALID, CONV_TRIG, IRQ;
   logic [ADDR_W-1:0] AWADDR, ARADDR;
   logic [DATA_W-1:0] WDATA, RDATA, rv;
   logic [STRB_W-1:0] WSTRB;
   logic [1:0]        BRESP, RRESP, rr;
   logic [PINS-1:0]   WAKE_IN, WAKE_REQ, pin_cmd;
   logic [3:0]        pin_dly;
   logic [31:0]       pat [4] = '{32'h0000_00FF, 32'h0000_0015, 32'h0000_002A, 32'h0000_0000};
   int                fail_count = 0, samples_checked = 0, trig_cnt = 0, base, tbase;
   int                req_cnt [PINS] = '{default: 0};

   wes_wakeup_edge_select dut (
      .MCLK(MCLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .WAKE_IN(WAKE_IN), .WAKE_REQ(WAKE_REQ), .CONV_TRIG(CONV_TRIG), .IRQ(IRQ)
   );
   wes_pin_model pins_i (.clk(MCLK), .cmd(pin_cmd), .dly(pin_dly), .pins(WAKE_IN));

   always #10 MCLK = ~MCLK;

   // Request pulses are counted per pin; one cycle gives one count.
   always @(posedge MCLK) begin
      for (int i = 0; i < PINS; i++) if (WAKE_REQ[i] === 1'b1) req_cnt[i]++;
      if (CONV_TRIG === 1'b1) trig_cnt++;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask

   // Write with address and data offered together.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge MCLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge MCLK);
         if (AWREADY === 1'b1) AWVALID <= 1'b0;
         if (WREADY === 1'b1) WVALID <= 1'b0;
         if (BVALID === 1'b1) break;
      end
      rr = BRESP;
      BREADY <= 1'b0;
      if (n == 40) begin
         fail_count++;
         close_out;
      end
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      @(posedge MCLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge MCLK);
         if (ARREADY === 1'b1) ARVALID <= 1'b0;
         if (RVALID === 1'b1) break;
      end
      rv = RDATA;
      rr = RRESP;
      RREADY <= 1'b0;
      if (n == 40) begin
         fail_count++;
         close_out;
      end
   endtask

   initial begin
      MCLK = 1'b0;
      RST_N = 1'b0;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA} = '0;
      WSTRB = 4'hF;
      pin_cmd = 6'h3F;
      pin_dly = 4'h0;
      repeat (6) @(posedge MCLK);
      RST_N <= 1'b1;
      // Reset values; pins held high give no event.
      rd(OFF_EDGE_POL); chk(rv, 32'h0000_00C0);
      rd(OFF_MASK); chk(rv, ZERO_WORD);
      rd(OFF_STATUS); chk(rv, ZERO_WORD);
      rd(OFF_LEVEL); chk(rv, 32'h0000_003F);
      $display("test 1 done");
      // Select bits read back; reserved bits stay one.
      for (int k = 0; k < 4; k++) begin
         wr(OFF_EDGE_POL, pat[k]); chk(32'(rr), 32'(RESP_OKAY));
         rd(OFF_EDGE_POL); chk(rv, {24'h00_0000, 2'h3, pat[k][5:0]});
      end
      $display("test 2 done");
      // Each pin, both polarities, the slower pins changing later.
      for (int i = 0; i < PINS; i++) begin
         for (int p = 0; p < 2; p++) begin
            wr(OFF_MASK, p ? 32'h0000_0001 << i : ZERO_WORD);
            wr(OFF_EDGE_POL, p ? 32'h0000_0001 << i : ZERO_WORD);
            pin_dly <= 4'(2 * i);
            base = req_cnt[i];
            tbase = trig_cnt;
            pin_cmd <= ~(6'h01 << i);
            repeat (20) @(posedge MCLK);
            chk(32'(req_cnt[i] - base), 32'(1 - p));
            pin_cmd <= 6'h3F;
            repeat (20) @(posedge MCLK);
            chk(32'(req_cnt[i] - base), 32'h0000_0001);
            chk(32'(trig_cnt - tbase), 32'(i == TRIG_PIN));
            rd(OFF_STATUS); chk(rv, 32'h0000_0001 << i);
            chk(32'(IRQ), 32'(p));
            wr(OFF_STATUS, 32'h0000_0001 << i);
            repeat (3) @(posedge MCLK);
            chk(32'(IRQ), ZERO_WORD);
         end
      end
      $display("test 3 done");
      // Refused and ignored accesses.
      wr(8'h10, 32'h0000_003F); chk(32'(rr), 32'(RESP_DECERR));
      wr(OFF_LEVEL, ZERO_WORD); chk(32'(rr), 32'(RESP_OKAY));
      rd(8'h01); chk(32'(rr), 32'(RESP_DECERR));
      chk(rv, ZERO_WORD);
      rd(OFF_LEVEL); chk(rv, 32'h0000_003F);
      // A write without byte lane zero is answered but leaves the mask alone.
      WSTRB <= 4'hE;
      wr(OFF_MASK, 32'h0000_003F); chk(32'(rr), 32'(RESP_OKAY));
      WSTRB <= 4'hF;
      rd(OFF_MASK); chk(rv, 32'h0000_0020);
      $display("test 4 done");
      close_out;
   end
endmodule // wes_wakeup_edge_select_tb_top

bind wes_wakeup_edge_select wes_props props_i (
   .MCLK(MCLK), .RST_N(RST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
   .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
   .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
   .RREADY(RREADY), .WAKE_REQ(WAKE_REQ), .CONV_TRIG(CONV_TRIG)
);
